/* File: adp_ports.sv */
// Upper address port and upper data-bus port with APB registers
`timescale 1ns/1ns
`include "adp_defines.svh"

module adp_ports (
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    input  wire logic                   ce,
    input  wire logic [2:0]             op_mode,
    input  wire logic                   hw_standby,
    input  wire logic                   sw_standby,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`ADP_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic                        pready,
    output logic [31:0]                 prdata,
    output logic                        pslverr,
    input  wire adp_pkg::adp_byte_t     bus_addr_hi,
    input  wire logic                   bus_addr_oe,
    input  wire logic                   bus_dram_sel,
    input  wire logic [1:0]             bus_dram_rc,
    input  wire adp_pkg::adp_byte_t     bus_data_out,
    input  wire logic                   bus_data_oe,
    output adp_pkg::adp_byte_t          bus_data_in,
    input  wire adp_pkg::adp_byte_t     p2_in,
    output adp_pkg::adp_byte_t          p2_out,
    output adp_pkg::adp_byte_t          p2_oe,
    output adp_pkg::adp_byte_t          p2_pullup,
    input  wire adp_pkg::adp_byte_t     p3_in,
    output adp_pkg::adp_byte_t          p3_out,
    output adp_pkg::adp_byte_t          p3_oe
);
    import adp_pkg::*;

    // ************************************************************
    // Storage and decode signals
    // ************************************************************
    adp_fn_e             fn;
    logic                bus3;
    adp_byte_t           ddr2;
    adp_byte_t           dr2;
    adp_byte_t           pcr2;
    adp_byte_t           ddr3;
    adp_byte_t           dr3;
    adp_byte_t           dir2;
    adp_byte_t           p2_sync;
    adp_byte_t           p3_sync;
    adp_byte_t           rd_p2;
    adp_byte_t           rd_p3;
    adp_byte_t           next_p2_out;
    adp_byte_t           next_p2_oe;
    adp_byte_t           next_p2_pu;
    logic [`ADP_IDX_W-1:0] idx;
    logic                aligned;
    logic                wr;
    logic                wr_lane;
    logic                rd_valid;
    logic [31:0]         next_prdata;
    logic                next_slverr;

    // ************************************************************
    // Pin synchronisation
    // ************************************************************

    // Pins are asynchronous, so both ports pass two flops
    adp_sync #(
        .W        (16)
    ) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .async_in ({p3_in, p2_in}),
        .sync_out ({p3_sync, p2_sync})
    );

    // Sampled data pins go straight back to the bus controller
    assign bus_data_in = p3_sync;

    // ************************************************************
    // Mode decode
    // ************************************************************

    // Reserved mode 0 falls back to bus function, the safe choice
    always_comb begin
        case (op_mode)
            `ADP_MODE_GPIO: fn = ADP_FN_GPIO;
            3'h5,
            `ADP_MODE_MIX_HI: fn = ADP_FN_BUS_OR_IN;
            default: fn = ADP_FN_BUS;
        endcase
    end

    // Data port is a bus in every expanded mode
    assign bus3 = (fn != ADP_FN_GPIO);

    // Direction forced to outputs while the port is an address bus
    assign dir2 = (fn == ADP_FN_BUS) ? `ADP_ALL_OUT : ddr2;

    // ************************************************************
    // APB decode
    // ************************************************************
    assign idx     = paddr[`ADP_ADDR_W-1:2];
    assign aligned = (paddr[1:0] == 2'h0);

    // Single wait-free access phase; ce low stalls the transfer
    assign pready  = penable && ce && rd_valid;
    assign wr      = psel && penable && pwrite && pready;
    assign wr_lane = wr && pstrb[0] && aligned;

    // Read capture flag, set by the setup cycle of each transfer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
        end else if (ce) begin
            rd_valid <= psel && !(penable && pready);
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************

    // Address port direction, writes ignored in bus-only modes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ddr2 <= `ADP_RST_BYTE;
        end else if (ce) begin
            if (hw_standby) begin
                ddr2 <= `ADP_RST_BYTE;
            end else if (wr_lane && idx == `ADP_IDX_P2_DIR && fn != ADP_FN_BUS) begin
                ddr2 <= pwdata[7:0];
            end
        end
    end

    // Address port data; software standby does not stop writes, hardware standby clears it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dr2 <= `ADP_RST_BYTE;
        end else if (ce) begin
            if (hw_standby) begin
                dr2 <= `ADP_RST_BYTE;
            end else if (wr_lane && idx == `ADP_IDX_P2_OUT) begin
                dr2 <= pwdata[7:0];
            end
        end
    end

    // Address port pull-up control
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pcr2 <= `ADP_RST_BYTE;
        end else if (ce) begin
            if (hw_standby) begin
                pcr2 <= `ADP_RST_BYTE;
            end else if (wr_lane && idx == `ADP_IDX_P2_PULL) begin
                pcr2 <= pwdata[7:0];
            end
        end
    end

    // Data port direction, stored even while the bus ignores it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ddr3 <= `ADP_RST_BYTE;
        end else if (ce) begin
            if (hw_standby) begin
                ddr3 <= `ADP_RST_BYTE;
            end else if (wr_lane && idx == `ADP_IDX_P3_DIR) begin
                ddr3 <= pwdata[7:0];
            end
        end
    end

    // Data port data
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dr3 <= `ADP_RST_BYTE;
        end else if (ce) begin
            if (hw_standby) begin
                dr3 <= `ADP_RST_BYTE;
            end else if (wr_lane && idx == `ADP_IDX_P3_OUT) begin
                dr3 <= pwdata[7:0];
            end
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************

    // Output bits read the latch, input bits read the pin
    assign rd_p2 = (dr2 & dir2) | (p2_sync & ~dir2);
    assign rd_p3 = (dr3 & ddr3) | (p3_sync & ~ddr3);

    // Unmapped or misaligned addresses answer zero with an error
    always_comb begin
        next_prdata = 32'h0000_0000;
        next_slverr = 1'b0;
        if (!aligned) begin
            next_slverr = 1'b1;
        end else begin
            case (idx)
                `ADP_IDX_P2_DIR:  next_prdata[7:0] = `ADP_DIR_READ;
                `ADP_IDX_P2_OUT:  next_prdata[7:0] = rd_p2;
                `ADP_IDX_P2_PULL: next_prdata[7:0] = pcr2;
                `ADP_IDX_P3_DIR:  next_prdata[7:0] = `ADP_DIR_READ;
                `ADP_IDX_P3_OUT:  next_prdata[7:0] = rd_p3;
                default:          next_slverr = 1'b1;
            endcase
        end
    end

    // Read data is registered; the setup cycle loads it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce && psel) begin
            prdata  <= next_prdata;
            pslverr <= next_slverr;
        end
    end

    // ************************************************************
    // Address port pin logic
    // ************************************************************
    generate
        for (genvar i = 0; i < 8; i++) begin : g_p2
            logic bus_fn;
            logic addr_bit;

            // Bus function per pin: all in modes 1-4, by direction in 5-6
            assign bus_fn = (fn == ADP_FN_BUS) ||
                            (fn == ADP_FN_BUS_OR_IN && ddr2[i]);

            // Lowest two pins carry row/column during DRAM cycles
            if (i < `ADP_DRAM_BITS) begin : g_dram
                assign addr_bit = bus_dram_sel ? bus_dram_rc[i] : bus_addr_hi[i];
            end else begin : g_plain
                assign addr_bit = bus_addr_hi[i];
            end

            // Bus value and enable come from the bus controller
            assign next_p2_out[i] = bus_fn ? addr_bit : dr2[i];
            assign next_p2_oe[i]  = !hw_standby &&
                                    (bus_fn ? bus_addr_oe : dir2[i]);

            // Pull-up only on an input pin outside bus-only modes
            assign next_p2_pu[i]  = !hw_standby && fn != ADP_FN_BUS &&
                                    pcr2[i] && !ddr2[i];
        end
    endgenerate

    // Registered pins; hardware standby clears enables and pull-ups, software standby changes nothing
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            p2_out    <= `ADP_RST_BYTE;
            p2_oe     <= `ADP_RST_BYTE;
            p2_pullup <= `ADP_RST_BYTE;
        end else if (ce) begin
            p2_out    <= next_p2_out;
            p2_oe     <= next_p2_oe;
            p2_pullup <= next_p2_pu;
        end
    end

    // ************************************************************
    // Data port pin logic
    // ************************************************************

    // Bus modes ignore direction; mode 7 uses it per pin
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            p3_out <= `ADP_RST_BYTE;
            p3_oe  <= `ADP_RST_BYTE;
        end else if (ce) begin
            p3_out <= bus3 ? bus_data_out : dr3;
            if (hw_standby) begin
                p3_oe <= `ADP_RST_BYTE;
            end else begin
                p3_oe <= bus3 ? {8{bus_data_oe}} : ddr3;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    logic rd_acc;
    assign rd_acc = psel && penable && !pwrite && pready && aligned;

    a_p2_bus_drive: assert property (
        ce && fn == ADP_FN_BUS && !hw_standby |=> p2_oe == {8{$past(bus_addr_oe)}})
        else $error("address port not under bus control");

    a_p2_addr_val: assert property (
        ce && fn == ADP_FN_BUS && !bus_dram_sel |=> p2_out == $past(bus_addr_hi))
        else $error("address byte not on pins");

    a_p2_mix_in: assert property (
        ce && fn == ADP_FN_BUS_OR_IN |=> (p2_oe & ~$past(ddr2)) == 8'h00)
        else $error("input pin driven in mixed mode");

    a_p2_gpio_pins: assert property (
        ce && fn == ADP_FN_GPIO && !hw_standby
        |=> p2_oe == $past(ddr2) && p2_out == $past(dr2))
        else $error("address port gpio mismatch");

    a_dir_read_ones: assert property (
        rd_acc && (idx == `ADP_IDX_P2_DIR || idx == `ADP_IDX_P3_DIR)
        |-> prdata == 32'h0000_00FF)
        else $error("direction read not all ones");

    a_hw_clear_regs: assert property (
        ce && hw_standby |=> {ddr2, dr2, pcr2, ddr3, dr3} == 40'h0 && p2_oe == 8'h00)
        else $error("hardware standby did not clear");

    a_sw_hold_regs: assert property (
        ce && sw_standby && !hw_standby && !wr |=> $stable({ddr2, dr2, pcr2, ddr3, dr3}))
        else $error("software standby lost state");

    a_p2_read_mix: assert property (
        rd_acc && idx == `ADP_IDX_P2_OUT |-> prdata[7:0] == $past(rd_p2))
        else $error("address port read wrong");

    a_pullup_on: assert property (
        ce && fn != ADP_FN_BUS && !hw_standby
        |=> p2_pullup == ($past(pcr2) & ~$past(ddr2)))
        else $error("pull-up state wrong");

    a_pullup_off: assert property (
        ce && (fn == ADP_FN_BUS || hw_standby) |=> p2_pullup == 8'h00)
        else $error("pull-up on in bus mode or standby");

    a_dram_rowcol: assert property (
        ce && fn == ADP_FN_BUS && bus_dram_sel |=> p2_out[1:0] == $past(bus_dram_rc))
        else $error("DRAM row/column missing");

    a_p3_bus_data: assert property (
        ce && bus3 && !hw_standby
        |=> p3_out == $past(bus_data_out) && p3_oe == {8{$past(bus_data_oe)}})
        else $error("data port not on bus");

    a_p3_gpio_pins: assert property (
        ce && !bus3 && !hw_standby |=> p3_oe == $past(ddr3) && p3_out == $past(dr3))
        else $error("data port gpio mismatch");

    a_p3_read_mix: assert property (
        rd_acc && idx == `ADP_IDX_P3_OUT |-> prdata[7:0] == $past(rd_p3))
        else $error("data port read wrong");

    c_pullup_write: cover property (wr_lane && idx == `ADP_IDX_P2_PULL);
    c_gpio_read:    cover property (rd_acc && fn == ADP_FN_GPIO && idx == `ADP_IDX_P2_OUT);
    c_sw_standby:   cover property (sw_standby && p2_oe != 8'h00);
    c_dram_cycle:   cover property (fn == ADP_FN_BUS && bus_dram_sel);

endmodule : adp_ports

/* File: adp_defines.svh */
// Offsets, reset values and mode codes of the address/data pin ports
`ifndef ADP_DEFINES_SVH
`define ADP_DEFINES_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define ADP_ADDR_W      18
`define ADP_IDX_W       16
`define ADP_IDX_P2_DIR  16'hFFC1
`define ADP_IDX_P2_OUT  16'hFFC3
`define ADP_IDX_P3_DIR  16'hFFC4
`define ADP_IDX_P3_OUT  16'hFFC6
`define ADP_IDX_P2_PULL 16'hFFD8

// ****************************************************************
// Reset values and fixed read values
// ****************************************************************
`define ADP_RST_BYTE    8'h00
`define ADP_DIR_READ    8'hFF
`define ADP_ALL_OUT     8'hFF

// ****************************************************************
// Operating mode codes and field positions
// ****************************************************************
`define ADP_MODE_BUS_LO 3'h1
`define ADP_MODE_BUS_HI 3'h4
`define ADP_MODE_MIX_HI 3'h6
`define ADP_MODE_GPIO   3'h7
`define ADP_DRAM_BITS   2

`endif

/* File: adp_pkg.sv */
// Types shared by the address/data pin port block
package adp_pkg;

    // Pin function of the upper address port
    typedef enum logic [1:0] {
        ADP_FN_BUS,
        ADP_FN_BUS_OR_IN,
        ADP_FN_GPIO
    } adp_fn_e;

    typedef logic [7:0] adp_byte_t;

endpackage : adp_pkg

/* File: adp_sync.sv */
// Two-flop synchroniser for the port pin inputs
`timescale 1ns/1ns

module adp_sync #(
    parameter int W = 16
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta     <= '0;
            sync_out <= '0;
        end else if (ce) begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule : adp_sync

/* File: adp_pin_model.sv */
// Board-side model of the pins of the address and data-bus ports
`timescale 1ns/1ns

module adp_pin_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] p2_out,
    input  wire logic [7:0] p2_oe,
    input  wire logic [7:0] p2_pullup,
    input  wire logic [7:0] p3_out,
    input  wire logic [7:0] p3_oe,
    input  wire logic [7:0] ext2,
    input  wire logic [7:0] ext2_en,
    input  wire logic [7:0] ext3,
    output logic      [7:0] p2_lvl,
    output logic      [7:0] p3_lvl
);
    // ****************************************************************
    // Floating pins
    // ****************************************************************
    // Undriven, unpulled pins toggle so a stale level never reads right
    logic [7:0] flt = 8'hA5;

    always @(posedge core_clk) begin
        flt <= ~flt;
    end

    // ****************************************************************
    // Wire resolution
    // ****************************************************************
    // Device driver wins, then the board device, then the pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (p2_oe[i]) begin
                p2_lvl[i] = p2_out[i];
            end else if (ext2_en[i]) begin
                p2_lvl[i] = ext2[i];
            end else if (p2_pullup[i]) begin
                p2_lvl[i] = 1'b1;
            end else begin
                p2_lvl[i] = flt[i];
            end
        end
    end

    // Data bus always has a board device holding it when released
    assign p3_lvl = (p3_oe & p3_out) | (~p3_oe & ext3);
endmodule : adp_pin_model

/* File: address_data_io_ports_tb.sv */
// Self-checking testbench for the address and data-bus pin ports
`timescale 1ns/1ns
`include "adp_defines.svh"

module address_data_io_ports_tb;
    import adp_pkg::*;
    // ****************************************************************
    // Stimulus and observation signals
    // ****************************************************************
    logic        core_clk     = 1'b0;
    logic        rst_n        = 1'b0;
    logic [2:0]  op_mode      = 3'h7;
    logic        hw_standby   = 1'b0;
    logic        sw_standby   = 1'b0;
    logic        ce           = 1'b1;
    logic [1:0]  byte_lo      = 2'h0; // Low address bits, nonzero only for the misaligned test
    logic        psel         = 1'b0;
    logic        penable      = 1'b0;
    logic        pwrite       = 1'b0;
    logic [17:0] paddr        = 18'h00000;
    logic [31:0] pwdata       = 32'h00000000;
    logic [7:0]  bus_addr_hi  = 8'h00;
    logic        bus_addr_oe  = 1'b0;
    logic        bus_dram_sel = 1'b0;
    logic [1:0]  bus_dram_rc  = 2'h0;
    logic [7:0]  bus_data_out = 8'h00;
    logic        bus_data_oe  = 1'b0;
    logic [7:0]  ext2         = 8'h00;
    logic [7:0]  ext2_en      = 8'hFF;
    logic [7:0]  ext3         = 8'h00;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    adp_byte_t   bus_data_in, p2_in, p2_out, p2_oe, p2_pullup, p3_in, p3_out, p3_oe;
    int          err_count    = 0;
    int          comparisons  = 0;
    // Model registers: address dir, address data, data dir, data data, pull-up
    logic [7:0]  m [5]        = '{default: 8'h00};
    logic [15:0] idx [5]      = '{`ADP_IDX_P2_DIR, `ADP_IDX_P2_OUT, `ADP_IDX_P3_DIR,
                                  `ADP_IDX_P3_OUT, `ADP_IDX_P2_PULL};

    always #10 core_clk = ~core_clk;

    adp_ports DUT (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .op_mode(op_mode),
        .hw_standby(hw_standby), .sw_standby(sw_standby), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .bus_addr_hi(bus_addr_hi),
        .bus_addr_oe(bus_addr_oe), .bus_dram_sel(bus_dram_sel), .bus_dram_rc(bus_dram_rc),
        .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe), .bus_data_in(bus_data_in),
        .p2_in(p2_in), .p2_out(p2_out), .p2_oe(p2_oe), .p2_pullup(p2_pullup),
        .p3_in(p3_in), .p3_out(p3_out), .p3_oe(p3_oe));

    adp_pin_model pins_i (.core_clk(core_clk), .p2_out(p2_out), .p2_oe(p2_oe),
        .p2_pullup(p2_pullup), .p3_out(p3_out), .p3_oe(p3_oe), .ext2(ext2),
        .ext2_en(ext2_en), .ext3(ext3), .p2_lvl(p2_in), .p3_lvl(p3_in));

    // ****************************************************************
    // Comparison, bus and model tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One APB transfer; waits one edge first so psel never toggles twice in a step
    task automatic apb(input logic [15:0] ix, input logic wr, input logic [7:0] wd,
                       output logic [7:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {ix, byte_lo};
        pwdata  <= {24'h000000, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk("pready", 8'h01, 8'h00);
        rd = prdata[7:0];
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Write and track; address direction writes are dropped in bus-only modes
    task automatic wreg(input int r, input logic [7:0] d);
        logic [7:0] rd;
        logic       er;
        apb(idx[r], 1'b1, d, rd, er);
        chk("write pslverr", 8'h00, {7'h00, er});
        if (r != 0 || op_mode >= 3'h5) m[r] = d;
    endtask : wreg

    // Read all five registers and compare with the model
    task automatic regs();
        logic [7:0] rd, d2, lv2, e;
        logic       er;
        d2  = (op_mode >= 3'h5) ? m[0] : 8'hFF;
        lv2 = (ext2 & ext2_en) | (~ext2_en & m[4] & ~d2);
        for (int r = 0; r < 5; r++) begin
            apb(idx[r], 1'b0, 8'h00, rd, er);
            case (r)
                0, 2:    e = 8'hFF;
                1:       e = (m[1] & d2) | (lv2 & ~d2);
                3:       e = (m[3] & m[2]) | (ext3 & ~m[2]);
                default: e = m[4];
            endcase
            chk($sformatf("read %h", idx[r]), e, rd);
            chk("read pslverr", 8'h00, {7'h00, er});
        end
    endtask : regs

    // Pin outputs, enables and pull-ups against the model for the current mode
    task automatic pins();
        logic [7:0] d2, o2, e2;
        d2 = (op_mode >= 3'h5) ? m[0] : 8'hFF;
        o2 = bus_addr_hi;
        if (bus_dram_sel) o2[1:0] = bus_dram_rc;
        e2 = (op_mode == 3'h7) ? m[0] : d2 & {8{bus_addr_oe}};
        if (op_mode == 3'h7) o2 = m[1];
        chk("p2_oe", e2, p2_oe);
        chk("p2_out", o2 & e2, p2_out & e2);
        chk("p2_pullup", (op_mode >= 3'h5) ? m[4] & ~m[0] : 8'h00, p2_pullup);
        if (op_mode == 3'h7) begin
            chk("p3_oe", m[2], p3_oe);
            chk("p3_out", m[3] & m[2], p3_out & m[2]);
        end else begin
            chk("p3_oe", {8{bus_data_oe}}, p3_oe);
            chk("p3_out", bus_data_out, p3_out);
        end
    endtask : pins

    task automatic rnd_bus();
        bus_addr_hi  <= 8'($urandom());
        bus_addr_oe  <= 1'($urandom());
        bus_dram_sel <= 1'($urandom());
        bus_dram_rc  <= 2'($urandom());
        bus_data_out <= 8'($urandom());
        bus_data_oe  <= 1'($urandom());
        ext2         <= 8'($urandom());
        ext3         <= 8'($urandom());
    endtask : rnd_bus

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    // ****************************************************************
    // Watchdog
    // ****************************************************************
    // Whole run is under a thousand cycles; this is ample margin
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        end_of_test();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [7:0] rd;
        logic       er;
        void'($urandom(20128));
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        rnd_bus();
        repeat (4) @(posedge core_clk);
        regs();
        pins();
        $display("reset values test done");
        // Single-chip mode with random register contents
        for (int k = 0; k < 4; k++) begin
            for (int r = 0; r < 5; r++) wreg(r, 8'($urandom()));
            rnd_bus();
            repeat (4) @(posedge core_clk);
            pins();
            regs();
        end
        $display("single-chip mode test done");
        // Released address pins: pull-up must hold the input bits high
        ext2_en <= 8'h00;
        wreg(4, 8'hFF);
        wreg(0, 8'h0F);
        repeat (4) @(posedge core_clk);
        pins();
        regs();
        ext2_en <= 8'hFF;
        $display("pull-up test done");
        // Reserved mode 0 and expanded modes: bus function in 0-4, bus or input in 5-6; direction writes ignored in 0-4
        for (int md = 0; md <= 6; md++) begin
            op_mode <= 3'(md);
            rnd_bus();
            wreg(0, 8'($urandom()));
            repeat (2) @(posedge core_clk);
            pins();
            bus_data_oe <= 1'b0;
            repeat (4) @(posedge core_clk);
            chk("bus_data_in", ext3, bus_data_in);
            regs();
        end
        $display("expanded mode test done");
        // Unmapped place: refused, nothing stored
        apb(16'hFFC2, 1'b0, 8'h00, rd, er);
        chk("unmapped pslverr", 8'h01, {7'h00, er});
        chk("unmapped prdata", 8'h00, rd);
        apb(16'hFFC5, 1'b1, 8'h5A, rd, er);
        chk("unmapped write pslverr", 8'h01, {7'h00, er});
        // Misaligned write to the address port data: refused, latch unchanged
        byte_lo = 2'h2;
        apb(idx[1], 1'b1, 8'hA5, rd, er);
        byte_lo = 2'h0;
        chk("misaligned write pslverr", 8'h01, {7'h00, er});
        regs();
        $display("unmapped address test done");
        // Software standby keeps everything, hardware standby clears it
        op_mode <= 3'h7;
        for (int r = 0; r < 5; r++) wreg(r, 8'($urandom()));
        sw_standby <= 1'b1;
        repeat (6) @(posedge core_clk);
        pins();
        sw_standby <= 1'b0;
        regs();
        // Clock enable low freezes state: a standby pulse then clears nothing
        ce         <= 1'b0;
        hw_standby <= 1'b1;
        repeat (3) @(posedge core_clk);
        hw_standby <= 1'b0;
        repeat (2) @(posedge core_clk);
        ce         <= 1'b1;
        pins();
        regs();
        $display("clock enable test done");
        hw_standby <= 1'b1;
        repeat (2) @(posedge core_clk);
        m = '{default: 8'h00};
        pins();
        hw_standby <= 1'b0;
        regs();
        $display("standby test done");
        end_of_test();
    end
endmodule : address_data_io_ports_tb
